// ---- design/dpbac_counter.sv ----
/*
  Burst address counter and stored repeat address of one port.
  Assumes: controls arrive through the carrier, synchronous to i_clock.
*/
`timescale 1ns/1ps
module dpbac_counter (
  input  wire logic   i_clock,
  input  wire logic   i_rst,
  dpbac_ctl_if.counter ctl
);

  logic [dpbac_pkg::ADDR_W-1:0] count;
  logic [dpbac_pkg::ADDR_W-1:0] reload;
  logic [dpbac_pkg::ADDR_W-1:0] next_count;
  logic [dpbac_pkg::ADDR_W-1:0] next_reload;
  dpbac_pkg::dpbac_op_type      op;

  // ---------------------------------------------------------------------
  // Next counter value
  // ---------------------------------------------------------------------
  always_comb begin
    op          = dpbac_pkg::dpbac_decode_op(ctl.load_n, ctl.advance_n, ctl.repeat_n);
    next_count  = count;
    next_reload = reload;
    case (op)
      dpbac_pkg::DPBAC_OP_LOAD: begin
        next_count  = ctl.ext_address; // see [R1]
        next_reload = ctl.ext_address; // see [R1]
      end
      dpbac_pkg::DPBAC_OP_STEP: begin
        // One binary sum over bank and word fields carries across banks
        next_count = count + dpbac_pkg::ADDR_STEP; // see [R2] see [R8] see [R9] see [R13]
      end
      dpbac_pkg::DPBAC_OP_HOLD: begin
        next_count = count; // see [R3]
      end
      dpbac_pkg::DPBAC_OP_REPEAT: begin
        next_count = reload; // see [R4]
      end
      default: begin
        next_count = count;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // Reset value is only for determinism; controller must load before repeat
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count  <= dpbac_pkg::ADDR_RESET;
      reload <= dpbac_pkg::ADDR_RESET; // see [R7]
    end else begin
      count  <= next_count;
      reload <= next_reload;
    end
  end

  assign ctl.address        = count;
  assign ctl.repeat_address = reload;

endmodule : dpbac_counter

// ---- design/dpbac_port.sv ----
/*
  One port of a bank-switched dual-port SRAM: address counter control, access
  decode toward the array, and flow-through or pipelined read data timing.
  Assumes: the array reads combinationally from o_array_address in the cycle
  after each edge; all inputs are synchronous to i_clock.
*/
// Operation
// [R1] Load strobe stores external address, repeat too
// [R2] Advance strobe increments counter by one
// [R3] Neither strobe: counter value is reused
// [R4] Repeat reloads last externally loaded address
// [R5] Load and repeat ignore selects, lanes
// [R6] Counter advances even when port deselected
// [R7] Repeat address meaningless until first load
// [R8] Word FFF steps into next bank
// [R9] Last bank last word wraps to zero
// [R10] Flow-through data now, pipelined one later
// [R11] Far controller keeps ports in different banks
// [R12] Access type from selects, lanes, direction
// [R13] Eighteen bit counter: bank over word
`timescale 1ns/1ps
module dpbac_port (
  input  wire logic                         i_clock,
  input  wire logic                         i_rst,
  input  wire logic [dpbac_pkg::ADDR_W-1:0] i_address,
  input  wire logic                         i_address_load_n,
  input  wire logic                         i_count_advance_n,
  input  wire logic                         i_repeat_n,
  input  wire logic                         i_chip_select_low_n,
  input  wire logic                         i_chip_select_high,
  input  wire logic [dpbac_pkg::LANES-1:0]  i_byte_lane_enable_n,
  input  wire logic                         i_write_n,
  input  wire logic                         i_output_enable_n,
  input  wire logic                         i_flow_through,
  input  wire logic [dpbac_pkg::DATA_W-1:0] i_write_data,
  input  wire logic [dpbac_pkg::DATA_W-1:0] i_array_rdata,
  input  wire logic [dpbac_pkg::BANK_W-1:0] i_far_bank,
  output logic      [dpbac_pkg::ADDR_W-1:0] o_array_address,
  output logic      [dpbac_pkg::LANES-1:0]  o_array_write_lane,
  output logic      [dpbac_pkg::LANES-1:0]  o_array_read_lane,
  output logic      [dpbac_pkg::DATA_W-1:0] o_array_write_data,
  output logic      [dpbac_pkg::DATA_W-1:0] o_read_data,
  output logic      [dpbac_pkg::LANES-1:0]  o_data_drive,
  output logic                              o_bank_conflict
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic port_selected(input logic cs_low_n, input logic cs_high);
    return !cs_low_n && cs_high;
  endfunction : port_selected

  // ---------------------------------------------------------------------
  // Address counter
  // ---------------------------------------------------------------------
  dpbac_ctl_if ctl ();

  // Only the counter strobes and i_address reach the counter; selects never do
  assign ctl.load_n      = i_address_load_n;  // see [R5]
  assign ctl.advance_n   = i_count_advance_n; // see [R6]
  assign ctl.repeat_n    = i_repeat_n;        // see [R5]
  assign ctl.ext_address = i_address;

  dpbac_counter u_counter (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .ctl     (ctl.counter)
  );

  assign o_array_address = ctl.address;

  // ---------------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------------
  logic [dpbac_pkg::LANES-1:0]  write_lane;
  logic [dpbac_pkg::LANES-1:0]  read_lane;
  logic [dpbac_pkg::DATA_W-1:0] write_data;
  logic [dpbac_pkg::LANES-1:0]  next_write_lane;
  logic [dpbac_pkg::LANES-1:0]  next_read_lane;
  logic [dpbac_pkg::DATA_W-1:0] next_write_data;
  logic                         selected;

  always_comb begin
    selected        = port_selected(i_chip_select_low_n, i_chip_select_high);
    next_write_lane = dpbac_pkg::LANE_NONE;
    next_read_lane  = dpbac_pkg::LANE_NONE;
    next_write_data = write_data;
    if (selected && !i_write_n) begin
      next_write_lane = ~i_byte_lane_enable_n; // see [R12]
      next_write_data = i_write_data;
    end else if (selected) begin
      next_read_lane = ~i_byte_lane_enable_n; // see [R12]
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      write_lane <= dpbac_pkg::LANE_NONE;
      read_lane  <= dpbac_pkg::LANE_NONE;
      write_data <= dpbac_pkg::DATA_RESET;
    end else begin
      write_lane <= next_write_lane;
      read_lane  <= next_read_lane;
      write_data <= next_write_data;
    end
  end

  assign o_array_write_lane = write_lane;
  assign o_array_read_lane  = read_lane;
  assign o_array_write_data = write_data;

  // ---------------------------------------------------------------------
  // Read data timing
  // ---------------------------------------------------------------------
  // Pipelined mode buys cycle time for one extra cycle of latency
  logic [dpbac_pkg::DATA_W-1:0] stage_data;
  logic [dpbac_pkg::LANES-1:0]  stage_lane;
  logic [dpbac_pkg::DATA_W-1:0] read_data;
  logic [dpbac_pkg::LANES-1:0]  drive;
  logic [dpbac_pkg::DATA_W-1:0] next_stage_data;
  logic [dpbac_pkg::LANES-1:0]  next_stage_lane;
  logic [dpbac_pkg::DATA_W-1:0] next_read_data;
  logic [dpbac_pkg::LANES-1:0]  next_drive;

  always_comb begin
    next_stage_data = i_array_rdata;
    next_stage_lane = read_lane;
    if (i_flow_through) begin
      next_read_data = i_array_rdata; // see [R10]
      next_drive     = read_lane;
    end else begin
      next_read_data = stage_data; // see [R10]
      next_drive     = stage_lane;
    end
    // Output enable is sampled, not asynchronous as on the pins
    if (i_output_enable_n) begin
      next_drive = dpbac_pkg::LANE_NONE;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stage_data <= dpbac_pkg::DATA_RESET;
      stage_lane <= dpbac_pkg::LANE_NONE;
      read_data  <= dpbac_pkg::DATA_RESET;
      drive      <= dpbac_pkg::LANE_NONE;
    end else begin
      stage_data <= next_stage_data;
      stage_lane <= next_stage_lane;
      read_data  <= next_read_data;
      drive      <= next_drive;
    end
  end

  assign o_read_data  = read_data;
  assign o_data_drive = drive;

  // ---------------------------------------------------------------------
  // Bank conflict flag
  // ---------------------------------------------------------------------
  // Only reports; avoiding the clash is up to the two controllers
  logic conflict;
  logic next_conflict;

  always_comb begin
    next_conflict = (dpbac_pkg::dpbac_bank_of(ctl.address) == i_far_bank); // see [R11]
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      conflict <= 1'b0;
    end else begin
      conflict <= next_conflict;
    end
  end

  assign o_bank_conflict = conflict;

  // ---------------------------------------------------------------------
  // Assertion helpers
  // ---------------------------------------------------------------------
  logic [dpbac_pkg::ADDR_W-1:0] last_load;
  logic                         loaded;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      last_load <= dpbac_pkg::ADDR_RESET;
      loaded    <= 1'b0;
    end else if (i_repeat_n && !i_address_load_n) begin
      last_load <= i_address;
      loaded    <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  AST_EXT_LOAD: assert property (@(posedge i_clock) disable iff (i_rst) // see [R1]
    (i_repeat_n && !i_address_load_n)
    |=> (o_array_address == $past(i_address)) && (ctl.repeat_address == $past(i_address)))
    else $error("external load not taken");

  AST_STEP: assert property (@(posedge i_clock) disable iff (i_rst) // see [R2]
    (i_repeat_n && i_address_load_n && !i_count_advance_n)
    |=> o_array_address == $past(o_array_address) + dpbac_pkg::ADDR_STEP)
    else $error("counter did not advance by one");

  AST_HOLD: assert property (@(posedge i_clock) disable iff (i_rst) // see [R3]
    (i_repeat_n && i_address_load_n && i_count_advance_n)
    |=> $stable(o_array_address))
    else $error("held counter changed");

  AST_REPEAT: assert property (@(posedge i_clock) disable iff (i_rst) // see [R4]
    (!i_repeat_n && loaded)
    |=> o_array_address == $past(last_load))
    else $error("repeat did not return to last load");

  AST_DESELECT_STEP: assert property (@(posedge i_clock) disable iff (i_rst) // see [R6]
    (i_repeat_n && i_address_load_n && !i_count_advance_n
     && !port_selected(i_chip_select_low_n, i_chip_select_high))
    |=> (o_array_address == $past(o_array_address) + dpbac_pkg::ADDR_STEP)
        && (o_array_write_lane == dpbac_pkg::LANE_NONE))
    else $error("deselected port failed to advance");

  AST_DESELECT_LOAD: assert property (@(posedge i_clock) disable iff (i_rst) // see [R5]
    (i_repeat_n && !i_address_load_n && &i_byte_lane_enable_n)
    |=> o_array_address == $past(i_address))
    else $error("load blocked by lane enables");

  AST_BANK_CROSS: assert property (@(posedge i_clock) disable iff (i_rst) // see [R8]
    (i_repeat_n && i_address_load_n && !i_count_advance_n
     && dpbac_pkg::dpbac_word_of(o_array_address) == dpbac_pkg::WORD_LAST
     && dpbac_pkg::dpbac_bank_of(o_array_address) != dpbac_pkg::BANK_LAST)
    |=> (dpbac_pkg::dpbac_word_of(o_array_address) == dpbac_pkg::WORD_FIRST)
        && (dpbac_pkg::dpbac_bank_of(o_array_address)
            == dpbac_pkg::dpbac_bank_of($past(o_array_address)) + dpbac_pkg::BANK_STEP))
    else $error("bank boundary not crossed");

  AST_WRAP: assert property (@(posedge i_clock) disable iff (i_rst) // see [R9]
    (i_repeat_n && i_address_load_n && !i_count_advance_n
     && dpbac_pkg::dpbac_bank_of(o_array_address) == dpbac_pkg::BANK_LAST
     && dpbac_pkg::dpbac_word_of(o_array_address) == dpbac_pkg::WORD_LAST)
    |=> o_array_address == dpbac_pkg::ADDR_RESET)
    else $error("top of last bank did not wrap to zero");

  AST_FLOW_DATA: assert property (@(posedge i_clock) disable iff (i_rst) // see [R10]
    i_flow_through |=> o_read_data == $past(i_array_rdata))
    else $error("flow-through data late");

  AST_PIPE_DATA: assert property (@(posedge i_clock) disable iff (i_rst) // see [R10]
    (!i_flow_through && $past(!i_rst)) |=> o_read_data == $past(i_array_rdata, 2))
    else $error("pipelined data not one cycle later");

  AST_WRITE_DECODE: assert property (@(posedge i_clock) disable iff (i_rst) // see [R12]
    port_selected(i_chip_select_low_n, i_chip_select_high) && !i_write_n
    |=> (o_array_write_lane == ~$past(i_byte_lane_enable_n))
        && (o_array_read_lane == dpbac_pkg::LANE_NONE))
    else $error("write lanes misdecoded");

  AST_CONFLICT: assert property (@(posedge i_clock) disable iff (i_rst) // see [R11]
    (dpbac_pkg::dpbac_bank_of(o_array_address) == i_far_bank) |=> o_bank_conflict)
    else $error("bank conflict not flagged");

  AST_NO_CONFLICT: assert property (@(posedge i_clock) disable iff (i_rst) // see [R11]
    (dpbac_pkg::dpbac_bank_of(o_array_address) != i_far_bank) |=> !o_bank_conflict)
    else $error("bank conflict flagged without a clash");

  AST_READ_DECODE: assert property (@(posedge i_clock) disable iff (i_rst) // see [R12]
    port_selected(i_chip_select_low_n, i_chip_select_high) && i_write_n
    |=> (o_array_read_lane == ~$past(i_byte_lane_enable_n))
        && (o_array_write_lane == dpbac_pkg::LANE_NONE))
    else $error("read lanes misdecoded");

  AST_DESELECT_IDLE: assert property (@(posedge i_clock) disable iff (i_rst) // see [R12]
    !port_selected(i_chip_select_low_n, i_chip_select_high)
    |=> (o_array_write_lane == dpbac_pkg::LANE_NONE)
        && (o_array_read_lane == dpbac_pkg::LANE_NONE))
    else $error("deselected port still accesses the array");

  AST_OE_OFF: assert property (@(posedge i_clock) disable iff (i_rst) // see [R12]
    i_output_enable_n |=> o_data_drive == dpbac_pkg::LANE_NONE)
    else $error("data driven with output enable off");

  AST_REPEAT_KEEP: assert property (@(posedge i_clock) disable iff (i_rst) // see [R4]
    !(i_repeat_n && !i_address_load_n)
    |=> $stable(ctl.repeat_address))
    else $error("repeat address changed without a load");

  // ---------------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------------
  COV_BURST: cover property (@(posedge i_clock) disable iff (i_rst)
    (i_repeat_n && !i_address_load_n)
    ##1 (i_repeat_n && i_address_load_n && !i_count_advance_n) [*3]);

  COV_REPEAT: cover property (@(posedge i_clock) disable iff (i_rst)
    (i_repeat_n && !i_address_load_n) ##[1:8] !i_repeat_n);

  COV_WRAP: cover property (@(posedge i_clock) disable iff (i_rst)
    (o_array_address == {dpbac_pkg::BANK_LAST, dpbac_pkg::WORD_LAST}
     && i_repeat_n && i_address_load_n && !i_count_advance_n));

  COV_PIPE_READ: cover property (@(posedge i_clock) disable iff (i_rst)
    (!i_flow_through && o_array_read_lane != dpbac_pkg::LANE_NONE)
    ##2 (o_data_drive != dpbac_pkg::LANE_NONE));

endmodule : dpbac_port

// ---- inc/dpbac_ctl_if.sv ----
/*
  Carrier between the port logic and its address counter.
  Assumes: both ends run on the same clock; controls are valid before each edge.
*/
`timescale 1ns/1ps
interface dpbac_ctl_if;
  logic                         load_n;
  logic                         advance_n;
  logic                         repeat_n;
  logic [dpbac_pkg::ADDR_W-1:0] ext_address;
  logic [dpbac_pkg::ADDR_W-1:0] address;
  logic [dpbac_pkg::ADDR_W-1:0] repeat_address;

  modport port (
    output load_n,
    output advance_n,
    output repeat_n,
    output ext_address,
    input  address,
    input  repeat_address
  );

  modport counter (
    input  load_n,
    input  advance_n,
    input  repeat_n,
    input  ext_address,
    output address,
    output repeat_address
  );
endinterface : dpbac_ctl_if

// ---- inc/dpbac_pkg.sv ----
/*
  Constants, types and small helpers shared by the burst address path of one
  port of a bank-switched dual-port SRAM.
  Assumes: included in compile order before the carrier interface and the design.
*/
package dpbac_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int BANK_W = 6;
  localparam int WORD_W = 12;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = 36;

  // ---------------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------------
  localparam int BANK_LSB = 12;
  localparam int BANK_MSB = 17;
  localparam int WORD_MSB = 11;

  localparam logic [ADDR_W-1:0] ADDR_STEP  = 18'h0_0001;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h0_0000;
  localparam logic [WORD_W-1:0] WORD_LAST  = 12'hFFF;
  localparam logic [WORD_W-1:0] WORD_FIRST = 12'h000;
  localparam logic [BANK_W-1:0] BANK_LAST  = 6'h3F;
  localparam logic [BANK_W-1:0] BANK_FIRST = 6'h00;
  localparam logic [BANK_W-1:0] BANK_STEP  = 6'h01;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;
  localparam logic [LANES-1:0]  LANE_NONE  = 4'h0;

  // ---------------------------------------------------------------------
  // Counter operations
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    DPBAC_OP_LOAD   = 2'b00,
    DPBAC_OP_STEP   = 2'b01,
    DPBAC_OP_HOLD   = 2'b10,
    DPBAC_OP_REPEAT = 2'b11
  } dpbac_op_type;

  // Repeat outranks everything; load outranks advance
  function automatic dpbac_op_type dpbac_decode_op(input logic load_n,
                                                   input logic advance_n,
                                                   input logic repeat_n);
    dpbac_op_type op;
    if (!repeat_n) begin
      op = DPBAC_OP_REPEAT;
    end else if (!load_n) begin
      op = DPBAC_OP_LOAD;
    end else if (!advance_n) begin
      op = DPBAC_OP_STEP;
    end else begin
      op = DPBAC_OP_HOLD;
    end
    return op;
  endfunction : dpbac_decode_op

  function automatic logic [BANK_W-1:0] dpbac_bank_of(input logic [ADDR_W-1:0] addr);
    return addr[BANK_MSB:BANK_LSB];
  endfunction : dpbac_bank_of

  function automatic logic [WORD_W-1:0] dpbac_word_of(input logic [ADDR_W-1:0] addr);
    return addr[WORD_MSB:0];
  endfunction : dpbac_word_of

endpackage : dpbac_pkg

// ---- verif/dpbac_ctl_model.sv ----
/*
  Stand-in for the external controller that drives one port's address strobes.
  Assumes: requests on i_op and i_addr change just after a rising edge of i_clock.
*/
`timescale 1ns/1ps
module dpbac_ctl_model (
  input  wire logic                         i_clock,
  input  wire logic                         i_rst,
  input  wire dpbac_pkg::dpbac_op_type      i_op,
  input  wire logic [dpbac_pkg::ADDR_W-1:0] i_addr,
  output logic      [dpbac_pkg::ADDR_W-1:0] o_address,
  output logic                              o_address_load_n,
  output logic                              o_count_advance_n,
  output logic                              o_repeat_n
);
  // ---------------------------------------------------------------------
  // Registered strobes, one request per edge
  // ---------------------------------------------------------------------
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_address_load_n  <= 1'b1;
      o_count_advance_n <= 1'b1;
      o_repeat_n        <= 1'b1;
      o_address         <= 18'h0_0000;
    end else begin
      o_address_load_n  <= (i_op != dpbac_pkg::DPBAC_OP_LOAD);
      o_count_advance_n <= (i_op != dpbac_pkg::DPBAC_OP_STEP);
      o_repeat_n        <= (i_op != dpbac_pkg::DPBAC_OP_REPEAT);
      // Unused bus carries junk, so a stale value cannot pass for a hold
      o_address <= (i_op == dpbac_pkg::DPBAC_OP_LOAD) ? i_addr : ~o_address;
    end
  end
endmodule : dpbac_ctl_model

// ---- verif/dpbac_port_tb_top.sv ----
/*
  Self-checking bench for one port: a cycle model compared at every falling edge.
  Assumes: the array is a combinational function of o_array_address.
*/
`timescale 1ns/1ps
module dpbac_port_tb_top;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [17:0] ad;
  logic ld_n, adv_n, rep_n, cs_l_n, cs_h, wr_n, oe_n, flow;
  logic [3:0] ln_n, wl, rl, drv;
  logic [35:0] wdata, rdata, awd, rd;
  logic [5:0] far;
  logic [17:0] aa;
  logic conf;
  dpbac_pkg::dpbac_op_type op;
  logic [17:0] op_addr;
  logic [31:0] seed = 32'h8f27_4f8d;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [17:0] e_a, p_a, e_rep;
  logic [3:0] e_wl, e_rl, e_drv, p_rl, o_rl;
  logic [35:0] e_wd, e_rd, p_rd, now_rd, m;
  logic e_conf, sel, live;

  always #5 i_clock = ~i_clock;
  // Stand-in array
  assign rdata = {aa, ~aa};

  dpbac_ctl_model i_dpbac_ctl_model (.i_clock(i_clock), .i_rst(i_rst), .i_op(op),
    .i_addr(op_addr), .o_address(ad), .o_address_load_n(ld_n),
    .o_count_advance_n(adv_n), .o_repeat_n(rep_n));

  dpbac_port i_dpbac_port (.i_clock(i_clock), .i_rst(i_rst), .i_address(ad),
    .i_address_load_n(ld_n), .i_count_advance_n(adv_n), .i_repeat_n(rep_n),
    .i_chip_select_low_n(cs_l_n), .i_chip_select_high(cs_h),
    .i_byte_lane_enable_n(ln_n), .i_write_n(wr_n), .i_output_enable_n(oe_n),
    .i_flow_through(flow), .i_write_data(wdata), .i_array_rdata(rdata),
    .i_far_bank(far), .o_array_address(aa), .o_array_write_lane(wl),
    .o_array_read_lane(rl), .o_array_write_data(awd), .o_read_data(rd),
    .o_data_drive(drv), .o_bank_conflict(conf));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // ---------------------------------------------------------------------
  // Reference model, updated at the same edges as the design
  // ---------------------------------------------------------------------
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      {e_a, e_rep, e_wl, e_rl, e_drv, p_rl, e_wd, e_rd, p_rd, e_conf} = '0;
      live = 1'b0;
    end else begin
      p_a = e_a;
      o_rl = e_rl;
      now_rd = {p_a, ~p_a};
      e_conf = (p_a[17:12] == far);
      if (!rep_n) e_a = e_rep;
      else if (!ld_n) begin
        e_a = ad;
        e_rep = ad;
      end else if (!adv_n) e_a = 18'((int'(e_a) + 1) % 262144);
      sel = !cs_l_n && cs_h;
      e_wl = (sel && !wr_n) ? ~ln_n : 4'h0;
      e_rl = (sel && wr_n) ? ~ln_n : 4'h0;
      if (sel && !wr_n) e_wd = wdata;
      if (flow) begin
        e_rd = now_rd;
        e_drv = o_rl & {4{!oe_n}};
      end else begin
        e_rd = p_rd;
        e_drv = p_rl & {4{!oe_n}};
      end
      p_rd = now_rd;
      p_rl = o_rl;
      live = 1'b1;
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [35:0] lanes(input logic [3:0] l);
    return {{9{l[3]}}, {9{l[2]}}, {9{l[1]}}, {9{l[0]}}};
  endfunction : lanes

  always @(negedge i_clock) begin
    if (!i_rst && live) begin
      chk(36'(aa), 36'(e_a));
      chk(36'(wl), 36'(e_wl));
      chk(36'(rl), 36'(e_rl));
      chk(awd & lanes(e_wl), e_wd & lanes(e_wl));
      chk(36'(drv), 36'(e_drv));
      m = lanes(e_drv);
      chk(rd & m, e_rd & m);
      chk(36'(conf), 36'(e_conf));
    end
  end

  // ---------------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------------
  task automatic cyc(input dpbac_pkg::dpbac_op_type o, input logic [17:0] a);
    @(posedge i_clock);
    seed = xs(seed);
    op <= o;
    op_addr <= a;
    cs_l_n <= seed[0];
    cs_h <= seed[1] | seed[2];
    ln_n <= seed[6:3];
    wr_n <= seed[7];
    oe_n <= seed[8] & seed[9];
    far <= seed[15:10];
    wdata <= {seed[31:16], seed[19:0]};
  endtask : cyc

  task automatic do_reset(input logic f);
    @(posedge i_clock);
    i_rst <= 1'b1;
    flow <= f;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
  endtask : do_reset

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic scene(input logic f);
    dpbac_pkg::dpbac_op_type r;
    do_reset(f);
    cyc(dpbac_pkg::DPBAC_OP_LOAD, 18'h2_A5C3);
    cyc(dpbac_pkg::DPBAC_OP_STEP, 18'h0_0000);
    cyc(dpbac_pkg::DPBAC_OP_HOLD, 18'h1_1111);
    cyc(dpbac_pkg::DPBAC_OP_REPEAT, 18'h0_0000);
    cyc(dpbac_pkg::DPBAC_OP_LOAD, 18'h0_0FFF);
    cyc(dpbac_pkg::DPBAC_OP_STEP, 18'h0_0000);
    cyc(dpbac_pkg::DPBAC_OP_LOAD, 18'h3_FFFF);
    cyc(dpbac_pkg::DPBAC_OP_STEP, 18'h0_0000);
    cyc(dpbac_pkg::DPBAC_OP_STEP, 18'h0_0000);
    cyc(dpbac_pkg::DPBAC_OP_REPEAT, 18'h0_0000);
    for (int i = 0; i < 600; i++) begin
      seed = xs(seed);
      r = dpbac_pkg::dpbac_op_type'(seed[29:28]);
      cyc(r, seed[17:0]);
    end
    repeat (3) cyc(dpbac_pkg::DPBAC_OP_HOLD, 18'h0_0000);
  endtask : scene

  initial begin
    op = dpbac_pkg::DPBAC_OP_HOLD;
    op_addr = 18'h0_0000;
    {cs_l_n, cs_h, wr_n, oe_n, flow} = 5'b1_0110;
    ln_n = 4'hF;
    far = 6'h00;
    wdata = 36'h0_0000_0000;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    scene(1'b1);
    scene(1'b0);
    conclude();
  end

  // Hang guard
  initial begin
    for (int i = 0; i < 20000; i++) @(posedge i_clock);
    n_mismatch++;
    conclude();
  end
endmodule : dpbac_port_tb_top
